// ---- hw/gref_regs.sv ----
/*
 * i2c slave register bank for genlock mode and reference control, with
 * reference selection, loss detection and status.
 * assumes i2c pins, sync inputs and mode/select pins are asynchronous.
 */
`timescale 1ns/100ps
`default_nettype none
`include "gref_defs.svh"
module gref_regs
	import gref_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic mode_pin_n_i,
	input wire logic ref_sel_pin_i,
	input wire logic [1:0] horizontal_reference_input_i,
	input wire logic [1:0] vref_i,
	input wire logic sd_pll_locked_i,
	input wire logic hd_pll_locked_i,
	input wire logic output_alignment_enable_i,
	output gref_cfg_t cfg_o,
	output logic ref_edge_o,
	output logic output_align_trigger_o,
	output logic no_reference_o
);
	logic [1:0] scl_s, sda_s, mpin_s, spin_s;
	logic [1:0] ha_s, hb_s, va_s, vb_s;
	logic [1:0] sdl_s, hdl_s;
	logic scl_d, sda_d, horizontal_reference_input_d;
	logic [7:0] mode_r, pol_r, rdiv_r, fblo_r, fbhi_r;
	logic [4:0] lockth_r;
	logic ref_valid_r, spin_d;
	logic [2:0] miss_r;
	logic [15:0] gap_r;
	gref_state_t st_r;
	logic [7:0] ptr_r, sh_r;
	logic [3:0] bit_r;
	logic rw_r, ofs_done_r, wr_step;
	logic scl_rise, scl_fall, start_c, stop_c;
	logic use_reg_sel, port_b, sync_mode, horizontal_reference_input_sel, horizontal_reference_input_act;
	logic [7:0] rd_byte;

	// two-flop synchronisers on every pin except output_alignment_enable_i
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			mpin_s <= 2'h3;
			spin_s <= 2'h0;
			ha_s <= 2'h0;
			hb_s <= 2'h0;
			va_s <= 2'h0;
			vb_s <= 2'h0;
			sdl_s <= 2'h0;
			hdl_s <= 2'h0;
		end else begin
			scl_s <= {scl_s[0], scl_i};
			sda_s <= {sda_s[0], sda_i};
			mpin_s <= {mpin_s[0], mode_pin_n_i};
			spin_s <= {spin_s[0], ref_sel_pin_i};
			ha_s <= {ha_s[0], horizontal_reference_input_i[0]};
			hb_s <= {hb_s[0], horizontal_reference_input_i[1]};
			va_s <= {va_s[0], vref_i[0]};
			vb_s <= {vb_s[0], vref_i[1]};
			sdl_s <= {sdl_s[0], sd_pll_locked_i};
			hdl_s <= {hdl_s[0], hd_pll_locked_i};
		end
	end

	// delayed copies for edge detection
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			horizontal_reference_input_d <= 1'b1; // matches horizontal_reference_input_act at reset, no false edge
			spin_d <= 1'b0;
		end else begin
			scl_d <= scl_s[1];
			sda_d <= sda_s[1];
			horizontal_reference_input_d <= horizontal_reference_input_act;
			spin_d <= spin_s[1];
		end
	end

	assign scl_rise = scl_s[1] & ~scl_d;
	assign scl_fall = ~scl_s[1] & scl_d;
	assign start_c = scl_s[1] & scl_d & sda_d & ~sda_s[1];
	assign stop_c = scl_s[1] & scl_d & ~sda_d & sda_s[1];

	// selection of mode and reference port
	assign use_reg_sel = pol_r[`GREF_OVRD_BIT] | mode_r[`GREF_RSRC_BIT];
	assign port_b = use_reg_sel ? mode_r[`GREF_REFERENCE_PORT_BIT_BIT] : spin_s[1];
	assign sync_mode = mode_r[`GREF_MSRC_BIT] ? mode_r[`GREF_MSEL_BIT] : ~mpin_s[1];
	assign horizontal_reference_input_sel = port_b ? hb_s[1] : ha_s[1];
	// active edge follows the programmed polarity
	assign horizontal_reference_input_act = horizontal_reference_input_sel ~^ (port_b ? pol_r[1] : pol_r[3]);

	assign cfg_o = '{miss_max: mode_r[2:0], holdover: mode_r[`GREF_HOLD_BIT],
		port_b: port_b, sync_mode: sync_mode,
		clock_ref: pol_r[`GREF_CLKREF_BIT], lock_thresh: lockth_r,
		ref_div_sel: rdiv_r[1:0], feedback_divider: {fbhi_r[4:0], fblo_r}};
	assign ref_edge_o = horizontal_reference_input_act & ~horizontal_reference_input_d;
	// override turns the select pin into an alignment pulse
	assign output_align_trigger_o = pol_r[`GREF_OVRD_BIT] & output_alignment_enable_i
		& spin_s[1] & ~spin_d;
	assign no_reference_o = ~ref_valid_r;

	// reference detector: missed line periods counted against threshold
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			gap_r <= 16'h0000;
			miss_r <= 3'h0;
			ref_valid_r <= 1'b0;
		end else if (!sync_mode) begin
			gap_r <= 16'h0000;
			miss_r <= 3'h0;
			ref_valid_r <= 1'b0;
		end else if (ref_edge_o || pol_r[`GREF_CLKREF_BIT] && horizontal_reference_input_act) begin
			gap_r <= 16'h0000;
			miss_r <= 3'h0;
			ref_valid_r <= 1'b1;
		end else if (gap_r == 16'(`GREF_MISS_CYC)) begin
			gap_r <= 16'h0000;
			if (miss_r >= mode_r[2:0])
				ref_valid_r <= 1'b0;
			else
				miss_r <= miss_r + 3'h1;
		end else begin
			gap_r <= gap_r + 16'h0001;
		end
	end

	// read data of the addressed register
	always_comb begin
		unique case (ptr_r)
			`GREF_OFS_MODE: rd_byte = mode_r;
			`GREF_OFS_STAT: rd_byte = {lockth_r, hdl_s[1], sdl_s[1],
				ref_valid_r};
			`GREF_OFS_POL: rd_byte = pol_r;
			`GREF_OFS_RDIV: rd_byte = rdiv_r;
			`GREF_OFS_FBLO: rd_byte = fblo_r;
			`GREF_OFS_FBHI: rd_byte = fbhi_r & `GREF_MASK_FBHI;
			default: rd_byte = 8'h00;
		endcase
	end

	// i2c slave byte engine
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= GREF_IDLE;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			rw_r <= 1'b0;
			ptr_r <= 8'h00;
			sda_oe_o <= 1'b0;
			ofs_done_r <= 1'b0;
		end else if (start_c) begin
			st_r <= GREF_ADDR;
			ofs_done_r <= 1'b0;
			bit_r <= 4'h0;
			sda_oe_o <= 1'b0;
		end else if (stop_c) begin
			st_r <= GREF_IDLE;
			sda_oe_o <= 1'b0;
		end else begin
			unique case (st_r)
				GREF_IDLE: ;
				GREF_ADDR, GREF_REG, GREF_WDATA: begin
					if (scl_rise) begin
						sh_r <= {sh_r[6:0], sda_s[1]};
						bit_r <= bit_r + 4'h1;
					end else if (scl_fall && bit_r == 4'h8) begin
						bit_r <= 4'h0;
						if (st_r == GREF_ADDR && sh_r[7:1] != `GREF_DEV_ADDR) begin
							st_r <= GREF_IDLE;
						end else begin
							sda_oe_o <= 1'b1;
							if (st_r == GREF_ADDR)
								rw_r <= sh_r[0];
							if (st_r == GREF_REG) begin
								ptr_r <= sh_r;
								ofs_done_r <= 1'b1;
							end
							if (wr_step)
								ptr_r <= ptr_r + 8'h01;
							st_r <= GREF_ACK;
						end
					end
				end
				GREF_ACK: begin
					if (scl_fall) begin
						if (rw_r) begin
							st_r <= GREF_RDATA;
							sh_r <= rd_byte;
							sda_oe_o <= ~rd_byte[7];
							bit_r <= 4'h1;
						end else begin
							// first byte after the address is the register offset
							st_r <= ofs_done_r ? GREF_WDATA : GREF_REG;
							sda_oe_o <= 1'b0;
						end
					end
				end
				GREF_RDATA: begin
					if (scl_fall) begin
						if (bit_r == 4'h8) begin
							sda_oe_o <= 1'b0;
							st_r <= GREF_RACK;
							ptr_r <= ptr_r + 8'h01;
						end else begin
							sda_oe_o <= ~sh_r[7 - bit_r[2:0]];
							bit_r <= bit_r + 4'h1;
						end
					end
				end
				GREF_RACK: begin
					if (scl_rise && sda_s[1])
						st_r <= GREF_IDLE;
					else if (scl_fall) begin
						st_r <= GREF_RDATA;
						sh_r <= rd_byte;
						sda_oe_o <= ~rd_byte[7];
						bit_r <= 4'h1;
					end
				end
			endcase
		end
	end

	assign sda_o = 1'b0;

	// register writes; pointer steps after every data byte
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode_r <= `GREF_RST_MODE;
			lockth_r <= `GREF_RST_LOCKTH;
			pol_r <= `GREF_RST_POL;
			rdiv_r <= `GREF_RST_RDIV;
			fblo_r <= `GREF_RST_FBLO;
			fbhi_r <= `GREF_RST_FBHI;
		end else if (st_r == GREF_WDATA && scl_fall && bit_r == 4'h8) begin
			unique case (ptr_r)
				`GREF_OFS_MODE: mode_r <= sh_r;
				`GREF_OFS_STAT: lockth_r <= sh_r[7:3];
				`GREF_OFS_POL: pol_r <= sh_r & `GREF_MASK_POL;
				`GREF_OFS_RDIV: rdiv_r <= sh_r & `GREF_MASK_RDIV;
				`GREF_OFS_FBLO: fblo_r <= sh_r;
				`GREF_OFS_FBHI: fbhi_r <= sh_r & `GREF_MASK_FBHI;
				default: ;
			endcase
		end
	end

	// end of a data byte: pointer steps for multi-byte writes
	assign wr_step = (st_r == GREF_WDATA) && scl_fall && (bit_r == 4'h8);
endmodule : gref_regs
`default_nettype wire

// ---- common/gref_defs.svh ----
/*
 * constants of the genlock reference control register bank: offsets,
 * field positions and reset values.
 * assumes inclusion by bare name from the package and the design.
 */
// What this block does
// - three-bit field sets missing sync pulses tolerated before reference loss
// - holdover bit chooses behaviour on reference loss
// - reference port bit picks port A at 0, port B at 1
// - pin override forces register selection; else source bit zero means pin
// - select source bit picks register bit at 1, pin at 0
// - with register mode source, mode bit 0 free run, 1 synchronised
// - mode source bit picks register bit at 1, mode pin at 0
// - reference present flag reads valid reference; no-reference pin is its inverse
// - free run mode holds reference present flag at zero
// - status bit 1 reports sd pll lock
// - status bit 2 reports hd pll lock
// - five-bit lock threshold feeds pll 1 lock detector
// - input_polarity_and_pin_override bits 0-3 hold sync polarities, 1 is active high
// - lock output clock to the active edge of selected horizontal sync
// - clock reference bit treats horizontal input as 27 MHz clock
// - override makes select pin an alignment pulse, honoured only when enabled
// - override clear with register selection ignores the shared pin
// - two-bit reference divider select is pll 1 ratio denominator
// - 13-bit feedback divider from feedback_divider_low and 05h bits 4-0
// - feedback_divider_high bits 7-5 read zero and ignore writes
// - multi-byte write stores each byte at the next register address
`ifndef GREF_DEFS_SVH
`define GREF_DEFS_SVH
`define GREF_DEV_ADDR 7'h6e
`define GREF_OFS_MODE 8'h00
`define GREF_OFS_STAT 8'h01
`define GREF_OFS_POL 8'h02
`define GREF_OFS_RDIV 8'h03
`define GREF_OFS_FBLO 8'h04
`define GREF_OFS_FBHI 8'h05
`define GREF_RST_MODE 8'ha3
`define GREF_RST_LOCKTH 5'h10
`define GREF_RST_POL 8'h00
`define GREF_RST_RDIV 8'h01
`define GREF_RST_FBLO 8'hb4
`define GREF_RST_FBHI 8'h06
`define GREF_MASK_POL 8'h3f
`define GREF_MASK_RDIV 8'h03
`define GREF_MASK_FBHI 8'h1f
`define GREF_HERR_LSB 0
`define GREF_HOLD_BIT 3
`define GREF_REFERENCE_PORT_BIT_BIT 4
`define GREF_RSRC_BIT 5
`define GREF_MSEL_BIT 6
`define GREF_MSRC_BIT 7
`define GREF_OVRD_BIT 5
`define GREF_CLKREF_BIT 4
`define GREF_HSYNC_NS 63556
`define GREF_CLK_NS 40
`define GREF_MISS_CYC ((`GREF_HSYNC_NS * 5 / 4 + `GREF_CLK_NS - 1) / `GREF_CLK_NS)
`endif

// ---- common/gref_pkg.sv ----
/*
 * types of the genlock reference control register bank.
 * assumes gref_defs.svh is on the include path.
 */
`include "gref_defs.svh"
package gref_pkg;
	typedef enum logic [2:0] {GREF_IDLE, GREF_ADDR, GREF_REG, GREF_WDATA, GREF_RDATA,
		GREF_ACK, GREF_RACK} gref_state_t;
	typedef struct packed {
		logic [2:0] miss_max;
		logic holdover;
		logic port_b;
		logic sync_mode;
		logic clock_ref;
		logic [4:0] lock_thresh;
		logic [1:0] ref_div_sel;
		logic [12:0] feedback_divider;
	} gref_cfg_t;
endpackage : gref_pkg

// ---- verification/gref_regs_properties.sv ----
/* port checker of the genlock reference register bank.
   assumes it is bound to gref_regs. */
`timescale 1ns/100ps
`default_nettype none
module gref_regs_properties
	import gref_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic scl_i,
	input wire logic sda_oe_o,
	input wire logic output_alignment_enable_i,
	input wire gref_cfg_t cfg_o,
	input wire logic ref_edge_o,
	input wire logic output_align_trigger_o,
	input wire logic no_reference_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	// acknowledge kept for eight cycles after it rises
	sequence s_held;
		sda_oe_o [*8];
	endsequence
	a_free_run_flag: assert property (!cfg_o.sync_mode [*4] |-> no_reference_o)
		else $error("no-reference low in free run");
	a_trig_enable: assert property (output_align_trigger_o |-> output_alignment_enable_i)
		else $error("trigger without enable");
	a_trig_pulse: assert property (output_align_trigger_o |=> !output_align_trigger_o)
		else $error("trigger longer than a cycle");
	a_edge_pulse: assert property (ref_edge_o |=> !ref_edge_o)
		else $error("edge longer than a cycle");
	a_thresh_write: assert property ($changed(cfg_o.lock_thresh) |-> !scl_i)
		else $error("threshold moved outside a write");
	a_div_write: assert property ($changed({cfg_o.ref_div_sel, cfg_o.feedback_divider})
		|-> !scl_i && !$past(scl_i))
		else $error("divider moved outside a write");
	a_ack_scl_low: assert property ($rose(sda_oe_o) |-> !scl_i)
		else $error("sda driven while scl high");
	a_ack_hold: assert property ($rose(sda_oe_o) |-> s_held)
		else $error("sda released too soon");
endmodule : gref_regs_properties
bind gref_regs gref_regs_properties u_props(.clk_sys_i, .nrst_i, .scl_i, .sda_oe_o,
	.output_alignment_enable_i, .cfg_o, .ref_edge_o, .output_align_trigger_o, .no_reference_o);
`default_nettype wire

// ---- verification/gref_i2c_host.sv ----
/* i2c bus master model facing the register bank.
   assumes the bench resolves sda as open drain with pull-up. */
`timescale 1ns/100ps
`default_nettype none
module gref_i2c_host (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	initial begin
		scl_o = 1;
		sda_o = 1;
	end
	// wait n clocks, then step off the edge
	task w(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask : w
	// sda falls while scl high
	task start;
		sda_o = 0;
		w(12);
		scl_o = 0;
	endtask : start
	task stop;
		w(4);
		sda_o = 0;
		w(12);
		scl_o = 1;
		w(12);
		sda_o = 1;
		w(12);
	endtask : stop
	// eight bits then a ninth; data moves well after scl falls
	task xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic k);
		for (int i = 8; i >= 0; i--) begin
			w(4);
			sda_o = (i > 0) ? d[i-1] : m;
			w(12);
			scl_o = 1;
			w(12);
			if (i > 0) q[i-1] = sda_i;
			else k = !sda_i;
			scl_o = 0;
		end
	endtask : xfer
endmodule : gref_i2c_host
`default_nettype wire

// ---- verification/testbench.sv ----
/* self-checking bench of the genlock reference register bank.
   assumes the host model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
`include "gref_defs.svh"
module testbench
	import gref_pkg::*;
;
	logic clk_sys_i = 0, nrst_i = 0, mode_pin_n_i = 1, ref_sel_pin_i = 0, en = 0;
	logic sd = 1, hd = 0, scl, sda_m, sda_oe, trig, no_ref, k;
	logic [1:0] horizontal_reference_input_i = 0, vref_i = 0;
	logic [7:0] q;
	gref_cfg_t cfg;
	int err_total = 0, n_checks = 0, trig_n = 0;
	wire logic sda = sda_m & ~sda_oe; // pull-up
	gref_regs dut(.clk_sys_i, .nrst_i, .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
		.mode_pin_n_i, .ref_sel_pin_i, .horizontal_reference_input_i, .vref_i, .sd_pll_locked_i(sd),
		.hd_pll_locked_i(hd), .output_alignment_enable_i(en), .cfg_o(cfg), .ref_edge_o(),
		.output_align_trigger_o(trig), .no_reference_o(no_ref));
	gref_i2c_host host(.clk_i(clk_sys_i), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
	initial forever #20 clk_sys_i = ~clk_sys_i;
	// sync inputs keep toggling
	initial forever begin
		repeat (64) @(posedge clk_sys_i);
		#2;
		horizontal_reference_input_i = ~horizontal_reference_input_i;
		vref_i = ~vref_i;
	end
	always @(posedge clk_sys_i) if (trig === 1'b1) trig_n++;
	task wt(input int n);
		repeat (n) @(posedge clk_sys_i);
		#2;
	endtask : wt
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task snd(input logic [7:0] b);
		host.xfer(b, 1'b1, q, k);
		chk(k, 1);
	endtask : snd
	task wr(input logic [7:0] o, input logic [31:0] d);
		host.start;
		snd({`GREF_DEV_ADDR, 1'b0});
		snd(o);
		for (int i = 3; i >= 0; i--) snd(d[8*i+:8]);
		host.stop;
	endtask : wr
	task rd(input logic [7:0] o, input logic [31:0] e);
		logic [31:0] r;
		host.start;
		snd({`GREF_DEV_ADDR, 1'b0});
		snd(o);
		host.stop;
		host.start;
		snd({`GREF_DEV_ADDR, 1'b1});
		for (int i = 3; i >= 0; i--) host.xfer(8'hff, i == 0, r[8*i+:8], k);
		host.stop;
		chk(r, e);
	endtask : rd
	// walk both pins; f set means register control
	task pins(input logic f);
		for (int i = 0; i < 4; i++) begin
			mode_pin_n_i = i[0];
			ref_sel_pin_i = i[1];
			wt(6);
			chk({cfg.sync_mode, cfg.port_b}, f ? 2'h3 : {~i[0], i[1]});
		end
	endtask : pins
	task pls;
		ref_sel_pin_i = 0;
		wt(10);
		ref_sel_pin_i = 1;
		wt(10);
	endtask : pls
	task wrap_up;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	initial begin
		#2000000;
		err_total++;
		wrap_up;
	end
	initial begin
		wt(6);
		nrst_i = 1;
		wt(4);
		rd(8'h00, 32'ha3820001);
		chk(no_ref, 1);
		sd = 0;
		hd = 1;
		rd(8'h04, 32'hb4060000);
		host.start;
		host.xfer(8'h42, 1'b1, q, k);
		host.stop;
		chk(k, 0);
		wr(8'h02, 32'h0f0234ff);
		rd(8'h01, 32'h840f0234);
		rd(8'h02, 32'h0f02341f);
		chk(cfg.feedback_divider, 13'h1f34);
		chk(cfg.ref_div_sel, 2'h2);
		wr(8'h00, 32'h5df80f02);
		chk({cfg.miss_max, cfg.holdover, cfg.lock_thresh}, 9'h17f);
		pins(1'b0);
		wr(8'h00, 32'hf0f80f02);
		pins(1'b1);
		wt(200);
		chk(no_ref, 0);
		wr(8'h00, 32'hc0f82f02);
		wt(6);
		chk(cfg.port_b, 0);
		en = 1;
		pls;
		chk(trig_n, 1);
		en = 0;
		pls;
		chk(trig_n, 1);
		wrap_up;
	end
endmodule : testbench
`default_nettype wire
